// *** rx_flow_pkg.sv ***
// constants shared by the receive free-buffer flow filter design
package rx_flow_pkg;
  // data path widths
  localparam int DATA_W         = 32;   // apb data width
  localparam int ADDR_W         = 12;   // decoded apb address bits
  localparam int LEVEL_W        = 8;    // threshold field width
  localparam int FREE_W         = 16;   // free-buffer counter width
  localparam int NUM_CH_DEFAULT = 8;    // receive channels
  localparam int CH_IDX_W       = 3;    // channel index width
  localparam int ADDR_STRIDE    = 4;    // one aligned word per register

  // register map (byte addresses)
  localparam logic [ADDR_W-1:0] ADDR_FILTER_LEVEL = 12'h000;  // low_priority_filter_level
  localparam logic [ADDR_W-1:0] ADDR_CONTROL      = 12'h004;  // enable and duplex control
  localparam logic [ADDR_W-1:0] ADDR_STATUS       = 12'h008;  // per-channel compare results
  localparam logic [ADDR_W-1:0] ADDR_FLOW_BASE    = 12'h040;  // channel_flow_level 0..7
  localparam logic [ADDR_W-1:0] ADDR_FREE_BASE    = 12'h080;  // channel_free_count 0..7

  // control register fields
  localparam int CTRL_PAUSE_EN_BIT = 0;  // rx_pause_generation_enable
  localparam int CTRL_FULL_DUP_BIT = 1;  // full duplex operation
  localparam int CTRL_W            = 2;  // implemented control bits

  // status register fields
  localparam int STAT_FILTER_LSB = 0;    // filter hits per channel
  localparam int STAT_FLOW_LSB   = 8;    // flow hits per channel

  // reset values
  localparam logic [LEVEL_W-1:0] LEVEL_RESET = 8'h00;
  localparam logic [FREE_W-1:0]  FREE_RESET  = 16'h0000;
  localparam logic [CTRL_W-1:0]  CTRL_RESET  = 2'h0;

  // byte address of a per-channel register
  function automatic logic [ADDR_W-1:0] chan_addr(input logic [ADDR_W-1:0] base, input int idx);
    chan_addr = base + ADDR_W'(idx * ADDR_STRIDE);
  endfunction
endpackage

// *** chan_if.sv ***
// signals between the register front end and one channel counter
`timescale 1ns/1ps
interface chan_if;
  logic                             wr_flow;       // write strobe for flow level
  logic                             wr_free;       // write-to-increment strobe
  logic [rx_flow_pkg::FREE_W-1:0]   wdata;         // write data, low bits
  logic                             consume;       // frame finished on this channel
  logic [rx_flow_pkg::FREE_W-1:0]   consume_cnt;   // buffers used by that frame
  logic [rx_flow_pkg::LEVEL_W-1:0]  filter_level;  // shared low-priority level
  logic [rx_flow_pkg::FREE_W-1:0]   free_count;    // current free buffers
  logic [rx_flow_pkg::LEVEL_W-1:0]  flow_level;    // channel flow level
  logic                             filter_hit;    // count below filter level
  logic                             flow_hit;      // count below flow level

  modport ctrl (output wr_flow, wr_free, wdata, consume, consume_cnt, filter_level,
                input  free_count, flow_level, filter_hit, flow_hit);
  modport chan (input  wr_flow, wr_free, wdata, consume, consume_cnt, filter_level,
                output free_count, flow_level, filter_hit, flow_hit);
endinterface

// *** channel_counter.sv ***
// one receive channel: flow level, free-buffer counter and compares
`timescale 1ns/1ps
module channel_counter (
  input wire logic pclk,     // system clock
  input wire logic presetn,  // async reset, active low
  chan_if.chan     bus       // strobes in, state out
);
  logic [rx_flow_pkg::FREE_W-1:0] next_free;  // counter after this cycle

  ////////////////////////////////////////////////////////////////////////////
  // flow level register, only the low byte of a write is kept
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus.flow_level <= rx_flow_pkg::LEVEL_RESET;
    end else if (bus.wr_flow) begin
      bus.flow_level <= bus.wdata[rx_flow_pkg::LEVEL_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // add and subtract in one sum so a write and a frame in the same cycle
  // both count; modulo 2^16 arithmetic gives the wrap on overflow
  always_comb begin
    next_free = bus.free_count;
    if (bus.wr_free) begin
      next_free = next_free + bus.wdata;
    end
    if (bus.consume) begin
      next_free = next_free - bus.consume_cnt;
    end
  end

  // free-buffer counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus.free_count <= rx_flow_pkg::FREE_RESET;
    end else begin
      bus.free_count <= next_free;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // strictly-below compare: a zero level can never hit
  assign bus.filter_hit = bus.free_count < {8'h00, bus.filter_level};
  assign bus.flow_hit   = bus.free_count < {8'h00, bus.flow_level};

  ////////////////////////////////////////////////////////////////////////////
  // checks
  a_free_write_adds: assert property (@(posedge pclk) disable iff (!presetn)
    bus.wr_free && !bus.consume |=> bus.free_count == $past(bus.free_count) + $past(bus.wdata))
    else $error("free count write did not add");

  a_free_wraps_zero: assert property (@(posedge pclk) disable iff (!presetn)
    bus.wr_free && !bus.consume && bus.free_count == 16'hFFFF && bus.wdata == 16'h0001
    |=> bus.free_count == 16'h0000)
    else $error("free count did not wrap to zero");

  a_frame_subtracts: assert property (@(posedge pclk) disable iff (!presetn)
    bus.consume && !bus.wr_free |=> bus.free_count == $past(bus.free_count) - $past(bus.consume_cnt))
    else $error("frame did not subtract buffers");

  a_zero_level_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    (bus.flow_level == 8'h00 |-> !bus.flow_hit) and (bus.filter_level == 8'h00 |-> !bus.filter_hit))
    else $error("zero level produced a hit");

  c_free_wrap: cover property (@(posedge pclk) disable iff (!presetn)
    bus.wr_free && bus.free_count == 16'hFFFF ##1 bus.free_count < 16'h0010);
endmodule

// *** rx_free_buffer_flow_filter.sv ***
// receive free-buffer accounting, thresholds and flow-control requests
//
// How it works
// - unused upper register bits read zero
// - shared eight-bit low-priority filter level register
// - per-channel eight-bit flow level, resets zero
// - per-channel sixteen-bit free count, compared for filtering
// - free count versus flow level gates flow control
// - writing free count adds the value
// - free count wraps to zero on overflow
// - each received frame subtracts its buffers
// - enabled trigger: collision half, pause full duplex
`timescale 1ns/1ps
module rx_free_buffer_flow_filter #(
  parameter int NUM_CH = rx_flow_pkg::NUM_CH_DEFAULT  // receive channels
) (
  input  wire logic                                pclk,                 // system clock
  input  wire logic                                presetn,              // async reset, active low
  input  wire logic                                psel,                 // apb select
  input  wire logic                                penable,              // apb access phase
  input  wire logic                                pwrite,               // apb direction
  input  wire logic [rx_flow_pkg::ADDR_W-1:0]      paddr,                // apb byte address
  input  wire logic [rx_flow_pkg::DATA_W-1:0]      pwdata,               // apb write data
  output      logic [rx_flow_pkg::DATA_W-1:0]      prdata,               // apb read data
  output      logic                                pready,               // apb ready
  output      logic                                pslverr,              // apb error, unmapped
  input  wire logic                                frame_done,           // frame stored, one pulse
  input  wire logic [rx_flow_pkg::CH_IDX_W-1:0]    frame_channel,        // channel of that frame
  input  wire logic [rx_flow_pkg::FREE_W-1:0]      frame_buffers,        // buffers the frame used
  output      logic [NUM_CH-1:0]                   low_priority_filter,  // drop low-priority frames
  output      logic [NUM_CH-1:0]                   flow_trigger,         // flow control per channel
  output      logic                                collision_request,    // half-duplex back-pressure
  output      logic                                pause_request         // full-duplex pause frame
);
  logic [rx_flow_pkg::LEVEL_W-1:0] filter_level;                      // shared filter level
  logic [rx_flow_pkg::CTRL_W-1:0]  control;                           // enable and duplex
  logic [rx_flow_pkg::FREE_W-1:0]  free_arr   [NUM_CH];               // per-channel counts
  logic [rx_flow_pkg::LEVEL_W-1:0] flow_arr   [NUM_CH];               // per-channel levels
  logic [NUM_CH-1:0]               filter_hits;                       // count below filter level
  logic [NUM_CH-1:0]               flow_hits;                         // count below flow level
  logic                            setup;                             // apb setup cycle
  logic                            wr_access;                         // write completes here
  logic [rx_flow_pkg::DATA_W-1:0]  next_rdata;                        // read data to capture
  logic                            next_mapped;                       // address decodes
  logic                            pause_en;                          // rx_pause_generation_enable
  logic                            full_dup;                          // full duplex operation

  assign setup     = psel && !penable;
  assign wr_access = psel && penable && pready && pwrite;
  assign pause_en  = control[rx_flow_pkg::CTRL_PAUSE_EN_BIT];
  assign full_dup  = control[rx_flow_pkg::CTRL_FULL_DUP_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // one counter per channel, joined by its own interface instance
  for (genvar g = 0; g < NUM_CH; g++) begin : chan_g
    chan_if bus ();
    assign bus.wr_flow      = wr_access && paddr == rx_flow_pkg::chan_addr(rx_flow_pkg::ADDR_FLOW_BASE, g);
    assign bus.wr_free      = wr_access && paddr == rx_flow_pkg::chan_addr(rx_flow_pkg::ADDR_FREE_BASE, g);
    assign bus.wdata        = pwdata[rx_flow_pkg::FREE_W-1:0];
    assign bus.consume      = frame_done && frame_channel == rx_flow_pkg::CH_IDX_W'(g);
    assign bus.consume_cnt  = frame_buffers;
    assign bus.filter_level = filter_level;
    assign free_arr[g]      = bus.free_count;
    assign flow_arr[g]      = bus.flow_level;
    assign filter_hits[g]   = bus.filter_hit;
    assign flow_hits[g]     = bus.flow_hit;
    channel_counter u_chan (
      .pclk    (pclk),
      .presetn (presetn),
      .bus     (bus.chan)
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // shared filter level, upper write bits discarded
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      filter_level <= rx_flow_pkg::LEVEL_RESET;
    end else if (wr_access && paddr == rx_flow_pkg::ADDR_FILTER_LEVEL) begin
      filter_level <= pwdata[rx_flow_pkg::LEVEL_W-1:0];
    end
  end

  // control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control <= rx_flow_pkg::CTRL_RESET;
    end else if (wr_access && paddr == rx_flow_pkg::ADDR_CONTROL) begin
      control <= pwdata[rx_flow_pkg::CTRL_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux; unlisted bits stay zero by the default
  always_comb begin
    next_rdata  = '0;
    next_mapped = 1'b0;
    if (paddr == rx_flow_pkg::ADDR_FILTER_LEVEL) begin
      next_rdata[rx_flow_pkg::LEVEL_W-1:0] = filter_level;
      next_mapped = 1'b1;
    end
    if (paddr == rx_flow_pkg::ADDR_CONTROL) begin
      next_rdata[rx_flow_pkg::CTRL_W-1:0] = control;
      next_mapped = 1'b1;
    end
    if (paddr == rx_flow_pkg::ADDR_STATUS) begin
      next_rdata[rx_flow_pkg::STAT_FILTER_LSB +: NUM_CH] = filter_hits;
      next_rdata[rx_flow_pkg::STAT_FLOW_LSB +: NUM_CH]   = flow_hits;
      next_mapped = 1'b1;
    end
    for (int i = 0; i < NUM_CH; i++) begin
      if (paddr == rx_flow_pkg::chan_addr(rx_flow_pkg::ADDR_FLOW_BASE, i)) begin
        next_rdata[rx_flow_pkg::LEVEL_W-1:0] = flow_arr[i];
        next_mapped = 1'b1;
      end
      if (paddr == rx_flow_pkg::chan_addr(rx_flow_pkg::ADDR_FREE_BASE, i)) begin
        next_rdata[rx_flow_pkg::FREE_W-1:0] = free_arr[i];
        next_mapped = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb answer: data captured in setup, one fixed access cycle; the read
  // shows the count as it stood at the setup edge, one cycle old
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= setup;
      pslverr <= setup && !next_mapped;
      prdata  <= (setup && !pwrite) ? next_rdata : '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered decisions towards the receive and transmit paths
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_priority_filter <= '0;
      flow_trigger        <= '0;
      collision_request   <= 1'b0;
      pause_request       <= 1'b0;
    end else begin
      low_priority_filter <= filter_hits;
      flow_trigger        <= pause_en ? flow_hits : '0;
      collision_request   <= pause_en && !full_dup && (|flow_hits);
      pause_request       <= pause_en && full_dup && (|flow_hits);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  a_free_read_upper: assert property (@(posedge pclk) disable iff (!presetn)
    pready && !pwrite && paddr >= rx_flow_pkg::ADDR_FREE_BASE |-> prdata[rx_flow_pkg::DATA_W-1:rx_flow_pkg::FREE_W] == '0)
    else $error("free count read shows upper bits");

  a_filter_level_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_access && paddr == rx_flow_pkg::ADDR_FILTER_LEVEL |=> filter_level == $past(pwdata[rx_flow_pkg::LEVEL_W-1:0]))
    else $error("filter level write lost");

  a_flow_level_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_access && paddr == rx_flow_pkg::ADDR_FLOW_BASE |=> flow_arr[0] == $past(pwdata[rx_flow_pkg::LEVEL_W-1:0]))
    else $error("channel 0 flow level write lost");

  a_flow_needs_enable: assert property (@(posedge pclk) disable iff (!presetn)
    !pause_en |=> flow_trigger == '0 && !collision_request && !pause_request)
    else $error("flow control raised while disabled");

  a_pause_full_dup: assert property (@(posedge pclk) disable iff (!presetn)
    pause_en && (|flow_hits) |=> (pause_request == $past(full_dup)) && (collision_request != $past(full_dup)))
    else $error("wrong flow action for duplex mode");

  a_frame_lowers: assert property (@(posedge pclk) disable iff (!presetn)
    frame_done && frame_channel == 3'h0 && !chan_g[0].bus.wr_free && frame_buffers != 16'h0000
    |=> free_arr[0] != $past(free_arr[0]))
    else $error("frame left channel 0 count unchanged");

  ////////////////////////////////////////////////////////////////////////////
  // bus answer checks: one fixed access cycle, quiet outside it, so a
  // master that samples late would see zeros rather than stale data
  a_ready_after_setup: assert property (@(posedge pclk) disable iff (!presetn)
    setup |=> pready)
    else $error("setup cycle not answered");

  a_ready_only_setup: assert property (@(posedge pclk) disable iff (!presetn)
    !setup |=> !pready)
    else $error("ready without a setup cycle");

  a_idle_bus_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    !pready |-> prdata == '0 && !pslverr)
    else $error("read data or error outside access cycle");

  // register content checks; stored bits only, upper bits never leak out
  a_filter_read_upper: assert property (@(posedge pclk) disable iff (!presetn)
    pready && !pwrite && paddr == rx_flow_pkg::ADDR_FILTER_LEVEL
    |-> prdata[rx_flow_pkg::DATA_W-1:rx_flow_pkg::LEVEL_W] == '0)
    else $error("filter level read shows upper bits");

  a_flow_read_upper: assert property (@(posedge pclk) disable iff (!presetn)
    pready && !pwrite && paddr >= rx_flow_pkg::ADDR_FLOW_BASE && paddr < rx_flow_pkg::ADDR_FREE_BASE
    |-> prdata[rx_flow_pkg::DATA_W-1:rx_flow_pkg::LEVEL_W] == '0)
    else $error("flow level read shows upper bits");

  a_filter_level_kept: assert property (@(posedge pclk) disable iff (!presetn)
    !(wr_access && paddr == rx_flow_pkg::ADDR_FILTER_LEVEL) |=> filter_level == $past(filter_level))
    else $error("filter level changed without a write");

  // decision checks towards the transmit side
  a_trigger_follows: assert property (@(posedge pclk) disable iff (!presetn)
    pause_en |=> flow_trigger == $past(flow_hits))
    else $error("flow trigger does not follow channel compares");

  a_no_hit_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    !(|flow_hits) |=> !collision_request && !pause_request)
    else $error("flow action without any channel below level");

  c_pause_sent: cover property (@(posedge pclk) disable iff (!presetn) pause_request);
  c_collision_sent: cover property (@(posedge pclk) disable iff (!presetn) collision_request);
  c_filter_active: cover property (@(posedge pclk) disable iff (!presetn) |low_priority_filter);
  c_unmapped_err: cover property (@(posedge pclk) disable iff (!presetn) pready && pslverr);
endmodule

// *** rx_free_buffer_flow_filter_bench.sv ***
// self-checking bench for the receive free-buffer flow filter, with an integer reference model
`timescale 1ns/1ps
module rx_free_buffer_flow_filter_bench;
  logic        pclk          = 1'b0;     // 100 MHz system clock
  logic        presetn       = 1'b0;     // async reset, active low
  logic        psel          = 1'b0;     // apb select
  logic        penable       = 1'b0;     // apb access phase
  logic        pwrite        = 1'b0;     // apb direction
  logic [11:0] paddr         = 12'h000;  // apb byte address
  logic [31:0] pwdata        = 32'h0;    // apb write data
  logic [31:0] prdata;                   // apb read data
  logic        pready;                   // apb ready
  logic        pslverr;                  // apb error
  logic        frame_done    = 1'b0;     // frame pulse
  logic [2:0]  frame_channel = 3'h0;     // frame channel
  logic [15:0] frame_buffers = 16'h0;    // buffers used
  logic [7:0]  low_priority_filter;      // filter outputs
  logic [7:0]  flow_trigger;             // flow outputs
  logic        collision_request;        // half-duplex request
  logic        pause_request;            // full-duplex request
  int          miscompares   = 0;        // mismatches seen
  int          total_checks  = 0;        // comparisons made
  int          flow_m [8];               // model flow levels
  int          free_m [8];               // model free counts
  int          filt_m;                   // model shared filter level
  int          ctrl_m;                   // model control bits
  logic [31:0] rd;                       // last read data
  logic        err;                      // last error flag

  // free-running clock, 10 ns period
  always #5 pclk = ~pclk;

  rx_free_buffer_flow_filter #(.NUM_CH(8)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .frame_done(frame_done), .frame_channel(frame_channel), .frame_buffers(frame_buffers),
    .low_priority_filter(low_priority_filter), .flow_trigger(flow_trigger),
    .collision_request(collision_request), .pause_request(pause_request)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // verdict: the one place where the run ends
  task automatic end_of_test;
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // compare one result, four-state exact
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one compare per kind of result: register data, bus error, decision output
  task automatic chk_rd(input string what, input logic [31:0] exp, input logic [31:0] got);
    chk(what, exp, got);
  endtask
  task automatic chk_err(input string what, input logic exp, input logic got);
    chk(what, {31'h0, exp}, {31'h0, got});
  endtask
  task automatic chk_out(input string what, input logic [7:0] exp, input logic [7:0] got);
    chk(what, {24'h0, exp}, {24'h0, got});
  endtask

  // addresses of the per-channel registers
  function automatic logic [11:0] flow_a(input int n);
    return rx_flow_pkg::ADDR_FLOW_BASE + 12'(4 * n);
  endfunction
  function automatic logic [11:0] free_a(input int n);
    return rx_flow_pkg::ADDR_FREE_BASE + 12'(4 * n);
  endfunction

  // reference read: expected data and error of an address
  function automatic logic [31:0] model_rd(input logic [11:0] a, output logic e);
    logic [31:0] v;
    e = 1'b0;
    v = 32'h0;
    if (a == rx_flow_pkg::ADDR_FILTER_LEVEL) v = 32'(filt_m);
    else if (a == rx_flow_pkg::ADDR_CONTROL) v = 32'(ctrl_m);
    else if (a == rx_flow_pkg::ADDR_STATUS) begin
      for (int n = 0; n < 8; n++) begin
        v[n]     = free_m[n] < filt_m;
        v[n + 8] = free_m[n] < flow_m[n];
      end
    end else begin
      e = 1'b1;
      for (int n = 0; n < 8; n++) begin
        if (a == flow_a(n)) begin
          v = 32'(flow_m[n]);
          e = 1'b0;
        end
        if (a == free_a(n)) begin
          v = 32'(free_m[n]);
          e = 1'b0;
        end
      end
    end
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // apb master: setup, then access held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      miscompares++;
      end_of_test();
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // write, check the error flag, then update the model
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic e;
    void'(model_rd(a, e));
    apb(1'b1, a, d);
    chk_err($sformatf("wr err %h", a), e, err);
    if (a == rx_flow_pkg::ADDR_FILTER_LEVEL) filt_m = d[7:0];
    if (a == rx_flow_pkg::ADDR_CONTROL) ctrl_m = d[1:0];
    for (int n = 0; n < 8; n++) begin
      if (a == flow_a(n)) flow_m[n] = d[7:0];
      if (a == free_a(n)) free_m[n] = (free_m[n] + d[15:0]) & 'hFFFF;
    end
  endtask

  // read and compare with the model, data and error
  task automatic rdchk(input logic [11:0] a);
    logic [31:0] v;
    logic        e;
    v = model_rd(a, e);
    apb(1'b0, a, 32'h0);
    chk_rd($sformatf("rd %h", a), v, rd);
    chk_err($sformatf("rd err %h", a), e, err);
  endtask

  // read back every register
  task automatic read_all;
    for (int n = 0; n < 8; n++) begin
      rdchk(flow_a(n));
      rdchk(free_a(n));
    end
    rdchk(rx_flow_pkg::ADDR_FILTER_LEVEL);
    rdchk(rx_flow_pkg::ADDR_CONTROL);
    rdchk(rx_flow_pkg::ADDR_STATUS);
  endtask

  // let the outputs settle, then compare them with the model
  task automatic check_outs;
    logic [7:0] ef;
    logic [7:0] fh;
    repeat (3) @(posedge pclk);
    for (int n = 0; n < 8; n++) begin
      ef[n] = free_m[n] < filt_m;
      fh[n] = free_m[n] < flow_m[n];
    end
    chk_out("filter", ef, low_priority_filter);
    chk_out("flow", fh & {8{ctrl_m[0]}}, flow_trigger);
    chk_out("collision", {7'h0, ctrl_m == 1 && fh != 0}, {7'h0, collision_request});
    chk_out("pause", {7'h0, ctrl_m == 3 && fh != 0}, {7'h0, pause_request});
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    int c;
    int b;
    void'($urandom(16111));
    filt_m = 0;
    ctrl_m = 0;
    for (int n = 0; n < 8; n++) begin
      flow_m[n] = 0;
      free_m[n] = 0;
    end
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    // reset values, then an unmapped read
    read_all();
    rdchk(12'hFFC);
    check_outs();
    // software preloads counts with junk in the unused upper bits
    wr(rx_flow_pkg::ADDR_FILTER_LEVEL, $urandom & 32'hFFFFFF3F);
    for (int n = 0; n < 8; n++) begin
      wr(flow_a(n), $urandom & 32'hFFFFFF7F);
      wr(free_a(n), $urandom & 32'hFFFF003F);
      wr(free_a(n), $urandom & 32'h0000001F);
    end
    // equal count and level is no hit, one above is
    wr(flow_a(0), 32'(free_m[0]));
    wr(flow_a(1), 32'(free_m[1] + 1));
    wr(free_a(7), 32'h0000FFFF);
    wr(rx_flow_pkg::ADDR_STATUS, 32'hFFFFFFFF);
    wr(12'h0FC, 32'h12345678);
    read_all();
    // every enable and duplex combination
    for (int m = 0; m < 4; m++) begin
      wr(rx_flow_pkg::ADDR_CONTROL, 32'hFFFFFFFC | m);
      check_outs();
    end
    // back-to-back random frames, enable on in half and full duplex
    for (int r = 0; r < 4; r++) begin
      wr(rx_flow_pkg::ADDR_CONTROL, 32'(1 + 2 * (r % 2)));
      for (int i = 0; i < 16; i++) begin
        @(posedge pclk);
        c = $urandom % 8;
        b = $urandom % 12;
        frame_done    <= 1'b1;
        frame_channel <= c[2:0];
        frame_buffers <= 16'(b);
        free_m[c] = (free_m[c] - b) & 'hFFFF;
      end
      @(posedge pclk);
      frame_done <= 1'b0;
      check_outs();
      read_all();
    end
    // zero filter level never filters
    wr(rx_flow_pkg::ADDR_FILTER_LEVEL, 32'h0);
    check_outs();
    end_of_test();
  end
endmodule
